//--- bench/dhsc_host_model.sv
`timescale 1ns/1ps
module dhsc_host_model (
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // reset, active low
  input wire logic slow_in, // stretch grant and completion
  input wire logic hold_req_in, // internal hold request
  input wire logic strobe_in, // transfer issued
  output logic hold_ack_out, // hold acknowledge
  output logic done_out // transfer complete
);
  // ---------------------------------------------------------------
  // arbiter
  // ---------------------------------------------------------------
  logic [1:0] wait_reg;
  logic pend_reg;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_reg <= 2'h0;
      pend_reg <= 1'b0;
      hold_ack_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      // the core keeps the bus for one cycle first, three cycles in slow mode
      wait_reg <= hold_req_in ? (wait_reg == 2'h0 ? 2'h0 : wait_reg - 2'h1) : {slow_in, 1'b1};
      hold_ack_out <= hold_req_in && wait_reg == 2'h0;
      // the modelled core makes no external references of its own
      pend_reg <= strobe_in;
      done_out <= slow_in ? pend_reg : strobe_in;
    end
  end
endmodule

//--- bench/dhsc_props.sv
`timescale 1ns/1ps
module dhsc_props (
  input logic clk_in, // core clock
  input logic rst_n_in, // reset, active low
  input logic psel_in, // apb select
  input logic penable_in, // apb enable
  input logic pready_out, // apb ready
  input logic pslverr_out, // apb error
  input logic [31:0] prdata_out, // apb read data
  input logic ext_hold_in, // external hold pin
  input logic dsp_hold_req_out, // internal hold request
  input logic hold_ack_in, // hold acknowledge
  input logic ext_strobe_out, // transfer issued
  input logic [31:0] ext_addr_out, // external address
  input logic ext_done_in // transfer complete
);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_pin_held;
    ext_hold_in [*3];
  endsequence
  sequence s_done;
    ext_done_in && dsp_hold_req_out;
  endsequence
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ready_const_a: assert property (pready_out)
    else $error("ready dropped");
  slverr_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error outside access phase");
  rdata_hold_a: assert property (!$past(psel_in && !penable_in) |-> $stable(prdata_out))
    else $error("read data moved outside setup");
  pin_priority_a: assert property (s_pin_held |-> !dsp_hold_req_out)
    else $error("internal request while pin held");
  strobe_grant_a: assert property (ext_strobe_out |-> $past(dsp_hold_req_out && hold_ack_in))
    else $error("transfer without grant");
  strobe_pulse_a: assert property (ext_strobe_out |=> !ext_strobe_out)
    else $error("strobe longer than one cycle");
  bus_release_a: assert property (s_done |=> !dsp_hold_req_out)
    else $error("bus not released after transfer");
  xaddr_hold_a: assert property (!ext_strobe_out |-> $stable(ext_addr_out))
    else $error("external address moved without transfer");
endmodule
bind dhsc_top dhsc_props props (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prdata_out(prdata_out), .ext_hold_in(ext_hold_in), .dsp_hold_req_out(dsp_hold_req_out),
  .hold_ack_in(hold_ack_in), .ext_strobe_out(ext_strobe_out), .ext_addr_out(ext_addr_out),
  .ext_done_in(ext_done_in));

//--- bench/tb_dsp_host_sync_control.sv
`timescale 1ns/1ps
`include "dhsc_consts.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_dsp_host_sync_control;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, xh = 0, slow = 0, er;
  logic [31:0] pa = 0, pwd = 0, rd, prdata, ea;
  logic [3:0] ps = 0, uo = 4'b1100;
  logic pready, pslverr, irq_n, nmi, req, ack, stb, done;
  logic [15:0] ewd;
  logic [31:0] sa[8];
  logic [15:0] sd[8];
  logic [31:0] st[4] = '{0, 2, 7, 10};
  logic [15:0] prog[11] = '{16'hf000, 16'h0, 16'he800, 16'h0, 16'h1008, 16'h6003,
    16'hf000, 16'hf800, 16'h001e, 16'h0031, 16'h1009};
  int ns = 0, n_errors = 0, samples_checked = 0, cyc = 0;
  always #50 clk = ~clk;
  dhsc_top DUT (.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(ps),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .interrupt_out_n_out(irq_n), .nmi_req_out(nmi), .ext_hold_in(xh),
    .dsp_hold_req_out(req), .hold_ack_in(ack), .ext_strobe_out(stb),
    .ext_addr_out(ea), .ext_wdata_out(ewd), .ext_done_in(done));
  dhsc_host_model host (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
    .hold_req_in(req), .strobe_in(stb), .hold_ack_out(ack), .done_out(done));
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    logic rdy;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d; ps <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rg(input logic w, input logic [5:0] o, input logic [31:0] d);
    apb(w, {`DHSC_REG_BASE_HI, 2'b00, o}, d, 4'hf);
  endtask
  // one ram word through its own byte lanes
  task automatic rw(input logic [10:0] l, input logic [15:0] v);
    apb(1'b1, 32'hfffe0000 + {l[10:1], 2'b00}, {v, v}, l[0] ? 4'hc : 4'h3);
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    do begin rg(1'b0, `DHSC_OFS_LSTAT, 0); i++; end while (rd[0] !== 1'b0 && i < 100);
  endtask
  // element address for pointer 0x01e, step exponent 1, wrap 3
  function automatic logic [10:0] xel(input int n);
    return (11'h01e & ~11'h003) + 11'((11'h01e + 2 * n) % 8);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (stb === 1'b1 && ns < 8) begin sa[ns] = ea; sd[ns] = ewd; ns++; end
    if (cyc == 20000) begin n_errors++; end_of_test; end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rg(1'b0, `DHSC_OFS_LSTAT, 0);
    `CHK("run", 1'b0, rd[`DHSC_BIT_RUN])
    rg(1'b0, `DHSC_OFS_EVEN, 0);
    `CHK("enable", `DHSC_RST_EVEN, rd[0])
    apb(1'b0, 32'hfffd0000, 0, 4'hf);
    `CHK("slverr", 1'b1, er)
    for (int k = 0; k < 11; k++) rw(11'(k), prog[k]);
    for (int k = 28; k < 36; k++) rw(11'(k), 16'hc000 | 16'(k));
    rw(11'h30, 16'h1234);
    rw(11'h31, 16'h5a5a);
    apb(1'b0, 32'hfffe0060, 0, 4'hf);
    `CHK("ram", 32'h5a5a1234, rd)
    rg(1'b1, `DHSC_OFS_GATE, 1);
    rg(1'b1, `DHSC_OFS_EVEN, 1);
    for (int k = 0; k < 4; k++) begin
      rg(1'b1, `DHSC_OFS_EVFLAG, 1);
      rg(1'b1, `DHSC_OFS_NMI, 3);
      rg(1'b1, `DHSC_OFS_COMMAND_LIST_POINTER, st[k]);
      wait_idle;
      rg(1'b0, `DHSC_OFS_EVFLAG, 0);
      `CHK("halt", 1'b1, rd[`DHSC_BIT_EV_HALT])
      rg(1'b0, `DHSC_OFS_NMI, 0);
      `CHK("undefined", uo[k], rd[`DHSC_BIT_NMI_UND])
      `CHK("nmi", uo[k], nmi)
      `CHK("irq", 1'b0, irq_n)
    end
    rg(1'b0, `DHSC_OFS_GATE, 0);
    `CHK("gate kept", 1'b1, rd[0])
    repeat (20) @(posedge clk);
    rg(1'b0, `DHSC_OFS_EVFLAG, 0);
    `CHK("sticky", 1'b1, rd[0])
    rg(1'b1, `DHSC_OFS_EVFLAG, 1);
    rg(1'b1, `DHSC_OFS_NMI, 3);
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'b1, irq_n)
    rg(1'b1, `DHSC_OFS_EXTBASE, 32'h00100000);
    rg(1'b1, `DHSC_OFS_COMMAND_LIST_POINTER, 4);
    repeat (30) @(posedge clk);
    rg(1'b0, `DHSC_OFS_LSTAT, 0);
    `CHK("running", 1'b1, rd[0])
    `CHK("gated", 0, ns)
    xh <= 1'b1;
    rg(1'b1, `DHSC_OFS_GATE, 0);
    repeat (30) @(posedge clk);
    `CHK("pin held", 0, ns)
    xh <= 1'b0;
    slow <= 1'b1;
    wait_idle;
    `CHK("count", 4, ns)
    for (int n = 0; n < 4; n++) begin
      `CHK("xaddr", 32'h00100000 + 2 * n, sa[n])
      `CHK("xdata", 16'hc000 | xel(n), sd[n])
    end
    rg(1'b1, `DHSC_OFS_GATE, 1);
    rg(1'b1, `DHSC_OFS_COMMAND_LIST_POINTER, 4);
    rw(11'h30, 16'hdead);
    wait_idle;
    `CHK("err nmi", 1'b1, nmi)
    rg(1'b0, `DHSC_OFS_NMI, 0);
    `CHK("err", 1'b1, rd[`DHSC_BIT_NMI_ERR])
    apb(1'b0, 32'hfffe0060, 0, 4'hf);
    `CHK("kept", 32'h5a5a1234, rd)
    rg(1'b1, `DHSC_OFS_NMI, 3);
    rg(1'b1, `DHSC_OFS_COMMAND_LIST_POINTER, 4);
    rg(1'b1, `DHSC_OFS_ABORT, 0);
    wait_idle;
    `CHK("abort", 1'b0, rd[0])
    `CHK("no nmi", 1'b0, nmi)
    end_of_test;
  end
endmodule

//--- hw/dhsc_consts.vh
`ifndef DHSC_CONSTS_VH
`define DHSC_CONSTS_VH
// ---------------------------------------------------------------
// address map
// ---------------------------------------------------------------
`define DHSC_RAM_BASE_HI 20'hfffe0
`define DHSC_REG_BASE_HI 24'hffff00
`define DHSC_RAM_WORDS 2048
`define DHSC_RAM_MAX 11'h7ff
`define DHSC_OFS_COMMAND_LIST_POINTER 6'h00
`define DHSC_OFS_LSTAT 6'h04
`define DHSC_OFS_ABORT 6'h08
`define DHSC_OFS_GATE 6'h0c
`define DHSC_OFS_EVFLAG 6'h10
`define DHSC_OFS_EVEN 6'h14
`define DHSC_OFS_NMI 6'h18
`define DHSC_OFS_EXTBASE 6'h1c
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DHSC_BIT_RUN 0
`define DHSC_BIT_GATE_HOLD 0
`define DHSC_BIT_EV_HALT 0
`define DHSC_BIT_NMI_ERR 0
`define DHSC_BIT_NMI_UND 1
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DHSC_RST_GATE 1'b0
`define DHSC_RST_EVEN 1'b0
`define DHSC_RST_EXTBASE 32'h00000000
// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define DHSC_OP_LOADX 5'h02
`define DHSC_OP_NOP 5'h10
`define DHSC_OP_EXTOUT 5'h0c
`define DHSC_OP_BREAK 5'h1d
`define DHSC_OP_HALT 5'h1e
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define DHSC_RELEASE_CYCLES 1
`endif

//--- hw/dhsc_top.v
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "dhsc_consts.vh"

module dhsc_top (
  input wire clk_in, // core clock
  input wire rst_n_in, // async reset, active low
  input wire ce_in, // clock enable
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb direction
  input wire [31:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  input wire [3:0] pstrb_in, // apb byte strobes
  output wire pready_out, // apb ready
  output wire [31:0] prdata_out, // apb read data
  output wire pslverr_out, // apb error
  output wire interrupt_out_n_out, // interrupt, active low
  output wire nmi_req_out, // nmi request level
  input wire ext_hold_in, // external hold pin
  output wire dsp_hold_req_out, // internal hold request
  input wire hold_ack_in, // internal hold acknowledge
  output wire ext_strobe_out, // external write strobe
  output wire [31:0] ext_addr_out, // external byte address
  output wire [15:0] ext_wdata_out, // external write data
  input wire ext_done_in // external transfer done
);

  // ---------------------------------------------------------------
  // reset and pin synchronisers
  // ---------------------------------------------------------------
  reg rst_s1_reg;
  reg rst_s2_reg;
  reg hold_s1_reg;
  reg hold_s2_reg;
  wire rst_n;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
    end else if (ce_in) begin
      hold_s1_reg <= ext_hold_in;
      hold_s2_reg <= hold_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // element n of a cyclic vector; ptr: [10:0] addr, [19:16] step, [23:20] wrap
  function [10:0] dhsc_cyc_addr;
    input [31:0] ptr;
    input [10:0] n;
    reg [10:0] base_mask;
    reg [10:0] wrap_mask;
    reg [10:0] sum;
    begin
      base_mask = ~((11'h001 << (ptr[23:20] - 4'h1)) - 11'h001);
      wrap_mask = (11'h001 << ptr[23:20]) - 11'h001;
      sum = ptr[10:0] + (n << ptr[19:16]);
      dhsc_cyc_addr = (ptr[10:0] & base_mask) + (sum & wrap_mask);
    end
  endfunction

  function dhsc_exempt;
    input [5:0] ofs;
    begin
      dhsc_exempt = (ofs != `DHSC_OFS_COMMAND_LIST_POINTER) && (ofs != `DHSC_OFS_EXTBASE);
    end
  endfunction

  // ---------------------------------------------------------------
  // execution states
  // ---------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_FETCH = 7'h02;
  localparam [6:0] ST_DECODE = 7'h04;
  localparam [6:0] ST_XREQ = 7'h08;
  localparam [6:0] ST_XACC = 7'h10;
  localparam [6:0] ST_XWAIT = 7'h20;
  localparam [6:0] ST_XREL = 7'h40;

  reg [15:0] ram_mem [0:`DHSC_RAM_WORDS-1];
  reg [6:0] state_reg;
  reg [10:0] pc_reg;
  reg [15:0] cmd_reg;
  reg [31:0] xptr_reg;
  reg [10:0] cnt_reg;
  reg [10:0] idx_reg;
  reg gate_hold_reg;
  reg ev_halt_reg;
  reg ev_en_reg;
  reg nmi_err_reg;
  reg nmi_und_reg;
  reg [31:0] extbase_reg;
  reg [31:0] prdata_reg;
  reg slverr_reg;
  reg irq_n_reg;
  reg strobe_reg;
  reg [31:0] ext_addr_reg;
  reg [15:0] ext_wdata_reg;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire running = (state_reg != ST_IDLE);
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire hit_ram = (paddr_in[31:12] == `DHSC_RAM_BASE_HI);
  wire hit_reg = (paddr_in[31:8] == `DHSC_REG_BASE_HI) & (paddr_in[7:6] == 2'b00);
  wire [5:0] ofs = {paddr_in[5:2], 2'b00};
  wire hit_known = hit_reg & (ofs <= `DHSC_OFS_EXTBASE);
  wire [10:0] ram_lo = {paddr_in[11:2], 1'b0};
  wire [10:0] ram_hi = {paddr_in[11:2], 1'b1};
  // while running, ram and the command list pointer and extbase registers are illegal; all other registers stay legal
  wire illegal = access & running & (hit_ram | (hit_known & ~dhsc_exempt(ofs)));
  wire wr_ok = access & pwrite_in & ~illegal;
  wire wr_reg = wr_ok & hit_known;
  wire start = wr_reg & (ofs == `DHSC_OFS_COMMAND_LIST_POINTER);
  wire abort = wr_reg & (ofs == `DHSC_OFS_ABORT);

  assign pready_out = 1'b1;
  assign prdata_out = prdata_reg;
  assign pslverr_out = slverr_reg & access;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire [4:0] opc = cmd_reg[15:11];
  wire [10:0] arg = cmd_reg[10:0];
  wire in_decode = (state_reg == ST_DECODE);
  wire op_stop = in_decode & ((opc == `DHSC_OP_HALT) | (opc == `DHSC_OP_BREAK));
  wire op_known = (opc == `DHSC_OP_HALT) | (opc == `DHSC_OP_BREAK) | (opc == `DHSC_OP_NOP) |
                  (opc == `DHSC_OP_LOADX) | (opc == `DHSC_OP_EXTOUT);
  wire op_odd = (opc == `DHSC_OP_LOADX) & arg[0];
  wire op_undef = in_decode & (~op_known | op_odd);
  wire terminate = running & (op_stop | op_undef | abort | illegal);
  wire ext_ok = ~gate_hold_reg & ~hold_s2_reg;

  // ---------------------------------------------------------------
  // external link and interrupt outputs
  // ---------------------------------------------------------------
  // hold request: not raised while gated or while the pin holds the bus
  assign dsp_hold_req_out = ((state_reg == ST_XREQ) & ext_ok) |
                            (state_reg == ST_XACC) | (state_reg == ST_XWAIT);
  assign ext_strobe_out = strobe_reg;
  assign ext_addr_out = ext_addr_reg;
  assign ext_wdata_out = ext_wdata_reg;
  assign interrupt_out_n_out = irq_n_reg;
  assign nmi_req_out = nmi_err_reg | nmi_und_reg;

  // ---------------------------------------------------------------
  // ram: cpu side when idle, execution side when running
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (ce_in && rst_n) begin
      if (wr_ok && hit_ram) begin
        if (pstrb_in[0]) begin
          ram_mem[ram_lo][7:0] <= pwdata_in[7:0];
        end
        if (pstrb_in[1]) begin
          ram_mem[ram_lo][15:8] <= pwdata_in[15:8];
        end
        if (pstrb_in[2]) begin
          ram_mem[ram_hi][7:0] <= pwdata_in[23:16];
        end
        if (pstrb_in[3]) begin
          ram_mem[ram_hi][15:8] <= pwdata_in[31:24];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads, latched in setup for a zero-wait access phase
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (ce_in && setup) begin
      slverr_reg <= ~(hit_ram | hit_known);
      prdata_reg <= 32'h00000000;
      if (hit_ram) begin
        // garbage-free zero while running stands for unpredictable data
        if (!running) begin
          prdata_reg <= {ram_mem[ram_hi], ram_mem[ram_lo]};
        end
      end else if (hit_known) begin
        case (ofs)
          `DHSC_OFS_COMMAND_LIST_POINTER: begin
            prdata_reg <= running ? 32'h00000000 : {21'h000000, pc_reg};
          end
          `DHSC_OFS_LSTAT: begin
            prdata_reg <= {31'h00000000, running};
          end
          `DHSC_OFS_GATE: begin
            prdata_reg <= {31'h00000000, gate_hold_reg};
          end
          `DHSC_OFS_EVFLAG: begin
            prdata_reg <= {31'h00000000, ev_halt_reg};
          end
          `DHSC_OFS_EVEN: begin
            prdata_reg <= {31'h00000000, ev_en_reg};
          end
          `DHSC_OFS_NMI: begin
            prdata_reg <= {30'h00000000, nmi_und_reg, nmi_err_reg};
          end
          `DHSC_OFS_EXTBASE: begin
            prdata_reg <= running ? 32'h00000000 : extbase_reg;
          end
          default: begin
            prdata_reg <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // control and status registers
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gate_hold_reg <= `DHSC_RST_GATE;
      ev_en_reg <= `DHSC_RST_EVEN;
      ev_halt_reg <= 1'b0;
      nmi_err_reg <= 1'b0;
      nmi_und_reg <= 1'b0;
      extbase_reg <= `DHSC_RST_EXTBASE;
      irq_n_reg <= 1'b1;
    end else if (ce_in) begin
      if (wr_reg && ofs == `DHSC_OFS_GATE) begin
        gate_hold_reg <= pwdata_in[`DHSC_BIT_GATE_HOLD];
      end
      if (wr_reg && ofs == `DHSC_OFS_EVEN) begin
        ev_en_reg <= pwdata_in[`DHSC_BIT_EV_HALT];
      end
      if (wr_reg && ofs == `DHSC_OFS_EXTBASE) begin
        extbase_reg <= pwdata_in;
      end
      // write one to clear; a new event in the same cycle wins
      if (terminate) begin
        ev_halt_reg <= 1'b1;
      end else if (wr_reg && ofs == `DHSC_OFS_EVFLAG && pwdata_in[`DHSC_BIT_EV_HALT]) begin
        ev_halt_reg <= 1'b0;
      end
      if (illegal && running) begin
        nmi_err_reg <= 1'b1;
      end else if (wr_reg && ofs == `DHSC_OFS_NMI && pwdata_in[`DHSC_BIT_NMI_ERR]) begin
        nmi_err_reg <= 1'b0;
      end
      if (op_undef) begin
        nmi_und_reg <= 1'b1;
      end else if (wr_reg && ofs == `DHSC_OFS_NMI && pwdata_in[`DHSC_BIT_NMI_UND]) begin
        nmi_und_reg <= 1'b0;
      end
      irq_n_reg <= ~((ev_halt_reg | terminate) & ev_en_reg);
    end
  end

  // ---------------------------------------------------------------
  // command-list execution unit
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      pc_reg <= 11'h000;
      cmd_reg <= 16'h0000;
      xptr_reg <= 32'h00000000;
      cnt_reg <= 11'h000;
      idx_reg <= 11'h000;
      strobe_reg <= 1'b0;
      ext_addr_reg <= 32'h00000000;
      ext_wdata_reg <= 16'h0000;
    end else if (ce_in) begin
      strobe_reg <= 1'b0;
      if (terminate) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (start) begin
              pc_reg <= pwdata_in[10:0] & `DHSC_RAM_MAX;
              state_reg <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            cmd_reg <= ram_mem[pc_reg];
            pc_reg <= pc_reg + 11'h001;
            state_reg <= ST_DECODE;
          end
          ST_DECODE: begin
            state_reg <= ST_FETCH;
            if (opc == `DHSC_OP_LOADX) begin
              xptr_reg <= {ram_mem[{arg[10:1], 1'b1}], ram_mem[{arg[10:1], 1'b0}]};
            end else if (opc == `DHSC_OP_EXTOUT) begin
              cnt_reg <= arg;
              idx_reg <= 11'h000;
              state_reg <= ST_XREQ;
            end
          end
          ST_XREQ: begin
            if (ext_ok && hold_ack_in) begin
              strobe_reg <= 1'b1;
              ext_addr_reg <= extbase_reg + {20'h00000, idx_reg, 1'b0};
              ext_wdata_reg <= ram_mem[dhsc_cyc_addr(xptr_reg, idx_reg)];
              state_reg <= ST_XACC;
            end
          end
          ST_XACC: begin
            if (ext_done_in) begin
              state_reg <= ST_XREL;
            end else begin
              state_reg <= ST_XWAIT;
            end
          end
          ST_XWAIT: begin
            if (ext_done_in) begin
              state_reg <= ST_XREL;
            end
          end
          ST_XREL: begin
            // request dropped here for one cycle so the core gets the bus
            if (idx_reg == cnt_reg) begin
              state_reg <= ST_FETCH;
            end else begin
              idx_reg <= idx_reg + 11'h001;
              state_reg <= ST_XREQ;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule
